// ### bwsc_consts.svh
/*
 * Offsets, field positions, reset values and counts for the bank window
 * and system control registers. Assumes inclusion by bare name.
 */
`ifndef BWSC_CONSTS_SVH
`define BWSC_CONSTS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define BWSC_OFS_BANK 8'h86
`define BWSC_OFS_POWER 8'h87
`define BWSC_OFS_CONFIG 8'hbf

// ************************************************************
// Field positions
// ************************************************************
`define BWSC_BANK_EN_BIT 7
`define BWSC_BANK_SEL_HI 5
`define BWSC_CFG_WDR_BIT 7
`define BWSC_CFG_XRAM_BIT 1
`define BWSC_CFG_LATCH_STROBE_INHIBIT_BIT 0
`define BWSC_PWR_BAUD_DOUBLER_BIT 7
`define BWSC_PWR_GFB_BIT 3
`define BWSC_PWR_GFA_BIT 2
`define BWSC_PWR_PD_BIT 1
`define BWSC_PWR_IDLE_BIT 0

// ************************************************************
// Reset values, window geometry and strobe timing
// ************************************************************
`define BWSC_RST_BYTE 8'h00
`define BWSC_RST_SEL 6'h00
`define BWSC_WIN_TAG 2'h1
`define BWSC_CORE_BLOCKS 6'h04
`define BWSC_ALE_LAST 3'h5
`define BWSC_ALE_HIGH_END 3'h2

`endif

// ### bwsc_pkg.sv
/*
 * Types shared by the bank window and system control logic.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package bwsc_pkg;
    typedef logic [7:0] bwsc_byte_t;
    typedef logic [11:0] bwsc_ram_addr_t;
    typedef logic [5:0] bwsc_block_t;
endpackage
`default_nettype wire

// ### bwsc_sysctrl.sv
/*
 * Bank window, system config and power control registers on the
 * special-function bus, with address mapping, latch strobe and power state.
 * Assumes all inputs come from logic on clk_in; the watchdog cause level
 * is held by the watchdog across and after the reset it causes.
 */
`default_nettype none
`include "bwsc_consts.svh"
module bwsc_sysctrl
    import bwsc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire bwsc_byte_t sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire bwsc_byte_t sfr_wdata_in,
    output bwsc_byte_t sfr_rdata_out,
    output logic sfr_hit_out,
    input wire bwsc_byte_t dir_addr_in,
    output bwsc_ram_addr_t ram_addr_out,
    output logic xram_sel_out,
    output logic xram_enable_out,
    input wire logic wdt_reset_cause_in,
    input wire logic irq_wake_in,
    output logic ale_out,
    output logic idle_out,
    output logic power_down_out,
    output logic baud_double_out
);
    // ************************************************************
    // State
    // ************************************************************
    logic window_enable_q;
    bwsc_block_t block_select_q;
    logic watchdog_reset_flag_q;
    logic cause_taken_q;
    logic expanded_ram_enable_q;
    logic latch_strobe_inhibit_q;
    logic baud_doubler_q;
    logic user_flag_b_q;
    logic user_flag_a_q;
    logic power_down_select_q;
    logic idle_q;
    logic [2:0] ale_cnt_q;
    bwsc_byte_t rdata_q;
    logic hit_q;
    bwsc_ram_addr_t ram_addr_q;
    logic xram_sel_q;
    logic ale_q;

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire logic sel_bank;
    wire logic sel_power;
    wire logic sel_config;
    wire logic wr_bank;
    wire logic wr_power;
    wire logic wr_config;
    wire logic any_sel;
    wire bwsc_byte_t bank_rd;
    wire bwsc_byte_t power_rd;
    wire bwsc_byte_t config_rd;
    wire bwsc_byte_t rd_mux;

    assign sel_bank = sfr_addr_in == `BWSC_OFS_BANK;
    assign sel_power = sfr_addr_in == `BWSC_OFS_POWER;
    assign sel_config = sfr_addr_in == `BWSC_OFS_CONFIG;
    assign any_sel = sel_bank || sel_power || sel_config;
    assign wr_bank = sfr_wr_in && sel_bank;
    assign wr_power = sfr_wr_in && sel_power;
    assign wr_config = sfr_wr_in && sel_config;

    // Unused bits read as zero
    assign bank_rd = {window_enable_q, 1'b0, block_select_q};
    assign power_rd = {baud_doubler_q, 3'h0, user_flag_b_q, user_flag_a_q,
                       power_down_select_q, idle_q};
    assign config_rd = {watchdog_reset_flag_q, 5'h00, expanded_ram_enable_q,
                        latch_strobe_inhibit_q};
    assign rd_mux = sel_bank ? bank_rd :
                    sel_power ? power_rd :
                    sel_config ? config_rd : `BWSC_RST_BYTE;

    // ************************************************************
    // Bank window register and address mapping
    // ************************************************************
    wire logic [11:0] map_addr;
    wire logic map_xram;

    bwsc_window_map bwsc_window_map_inst (
        .win_en_in(window_enable_q),
        .block_in(block_select_q),
        .dir_addr_in(dir_addr_in),
        .ram_addr_out(map_addr),
        .xram_sel_out(map_xram)
    );

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            window_enable_q <= 1'b0;
            block_select_q <= `BWSC_RST_SEL;
        end else if (wr_bank) begin
            window_enable_q <= sfr_wdata_in[`BWSC_BANK_EN_BIT];
            block_select_q <= sfr_wdata_in[`BWSC_BANK_SEL_HI:0];
        end
    end

    // Registered mapping costs one cycle but keeps outputs glitch free
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ram_addr_q <= 12'h000;
            xram_sel_q <= 1'b0;
        end else begin
            ram_addr_q <= map_addr;
            xram_sel_q <= map_xram;
        end
    end

    // ************************************************************
    // System config register
    // ************************************************************
    wire logic cause_capture;
    wire logic wdr_clear;

    assign cause_capture = !cause_taken_q && wdt_reset_cause_in;
    // Writing zero clears the flag; a fresh capture wins
    assign wdr_clear = wr_config && !sfr_wdata_in[`BWSC_CFG_WDR_BIT];

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cause_taken_q <= 1'b0;
            watchdog_reset_flag_q <= 1'b0;
        end else begin
            cause_taken_q <= 1'b1;
            if (cause_capture) begin
                watchdog_reset_flag_q <= 1'b1;
            end else if (wdr_clear) begin
                watchdog_reset_flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            expanded_ram_enable_q <= 1'b0;
            latch_strobe_inhibit_q <= 1'b0;
        end else if (wr_config) begin
            expanded_ram_enable_q <= sfr_wdata_in[`BWSC_CFG_XRAM_BIT];
            latch_strobe_inhibit_q <= sfr_wdata_in[`BWSC_CFG_LATCH_STROBE_INHIBIT_BIT];
        end
    end

    // ************************************************************
    // Latch strobe divider
    // ************************************************************
    wire logic ale_wrap;
    wire logic ale_high;

    assign ale_wrap = ale_cnt_q == `BWSC_ALE_LAST;
    assign ale_high = ale_cnt_q < `BWSC_ALE_HIGH_END;

    // Divider keeps running when inhibited so re-enable stays in phase
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ale_cnt_q <= 3'h0;
            ale_q <= 1'b0;
        end else begin
            ale_cnt_q <= ale_wrap ? 3'h0 : ale_cnt_q + 3'h1;
            ale_q <= ale_high && !latch_strobe_inhibit_q;
        end
    end

    // ************************************************************
    // Power control register
    // ************************************************************
    wire logic idle_set;
    wire logic idle_wake;

    assign idle_set = wr_power && sfr_wdata_in[`BWSC_PWR_IDLE_BIT];
    // Power-down has no wake here; only reset leaves it
    assign idle_wake = idle_q && irq_wake_in && !power_down_select_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            baud_doubler_q <= 1'b0;
            user_flag_b_q <= 1'b0;
            user_flag_a_q <= 1'b0;
            power_down_select_q <= 1'b0;
        end else if (wr_power) begin
            baud_doubler_q <= sfr_wdata_in[`BWSC_PWR_BAUD_DOUBLER_BIT];
            user_flag_b_q <= sfr_wdata_in[`BWSC_PWR_GFB_BIT];
            user_flag_a_q <= sfr_wdata_in[`BWSC_PWR_GFA_BIT];
            power_down_select_q <= power_down_select_q
                                   | sfr_wdata_in[`BWSC_PWR_PD_BIT];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            idle_q <= 1'b0;
        end else if (idle_set) begin
            idle_q <= 1'b1;
        end else if (idle_wake) begin
            idle_q <= 1'b0;
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= `BWSC_RST_BYTE;
            hit_q <= 1'b0;
        end else begin
            rdata_q <= sfr_rd_in ? rd_mux : `BWSC_RST_BYTE;
            hit_q <= (sfr_rd_in || sfr_wr_in) && any_sel;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign sfr_rdata_out = rdata_q;
    assign sfr_hit_out = hit_q;
    assign ram_addr_out = ram_addr_q;
    assign xram_sel_out = xram_sel_q;
    assign xram_enable_out = expanded_ram_enable_q;
    assign ale_out = ale_q;
    assign idle_out = idle_q;
    assign power_down_out = power_down_select_q;
    assign baud_double_out = baud_doubler_q;
endmodule // bwsc_sysctrl
`default_nettype wire

// ### bwsc_sysctrl_props.sv
/* Concurrent checks on the bank window and system control block.
   Assumes binding onto bwsc_sysctrl, single clock clk_in. */
`default_nettype none
`include "bwsc_consts.svh"
module bwsc_sysctrl_props
    import bwsc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire bwsc_byte_t sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire bwsc_byte_t sfr_wdata_in,
    input wire bwsc_byte_t dir_addr_in,
    input wire bwsc_ram_addr_t ram_addr_out,
    input wire logic xram_sel_out,
    input wire logic xram_enable_out,
    input wire logic irq_wake_in,
    input wire logic ale_out,
    input wire logic idle_out,
    input wire logic power_down_out,
    input wire logic baud_double_out
);
    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire pwr_wr = sfr_wr_in && (sfr_addr_in == `BWSC_OFS_POWER);
    wire in_win = (dir_addr_in[7:6] == `BWSC_WIN_TAG);
    win_low_a: assert property (in_win |=> ram_addr_out[5:0] == $past(dir_addr_in[5:0]))
        else $error("window offset lost");
    pass_thru_a: assert property (!in_win |=> ram_addr_out == {4'h0, $past(dir_addr_in)}
        && !xram_sel_out)
        else $error("address outside window altered");
    core_range_a: assert property (!xram_sel_out |-> ram_addr_out[11:8] == 4'h0)
        else $error("core RAM address too high");
    xram_range_a: assert property (xram_sel_out |-> ram_addr_out <= 12'heff)
        else $error("expanded address out of range");
    ale_high_a: assert property (ale_out && $past(ale_out) |=> !ale_out)
        else $error("strobe high too long");
    ale_low_a: assert property ($fell(ale_out) |-> !ale_out [*4])
        else $error("strobe low too short");
    idle_set_a: assert property (pwr_wr && sfr_wdata_in[0] |=> idle_out)
        else $error("idle not entered");
    idle_wake_a: assert property (idle_out && irq_wake_in && !power_down_out
        && !(pwr_wr && sfr_wdata_in[0]) |=> !idle_out)
        else $error("idle not left on wake");
    pd_set_a: assert property (pwr_wr && sfr_wdata_in[1] |=> power_down_out)
        else $error("power-down not entered");
    pd_hold_a: assert property (power_down_out |=> power_down_out)
        else $error("power-down left without reset");
    baud_wr_a: assert property (pwr_wr |=> baud_double_out == $past(sfr_wdata_in[7]))
        else $error("baud doubler not stored");
    xram_wr_a: assert property (sfr_wr_in && sfr_addr_in == `BWSC_OFS_CONFIG
        |=> xram_enable_out == $past(sfr_wdata_in[1]))
        else $error("expanded RAM enable not stored");
endmodule // bwsc_sysctrl_props
bind bwsc_sysctrl bwsc_sysctrl_props bwsc_sysctrl_props_inst (.clk_in(clk_in), .rst_in(rst_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in),
    .dir_addr_in(dir_addr_in), .ram_addr_out(ram_addr_out), .xram_sel_out(xram_sel_out),
    .xram_enable_out(xram_enable_out), .irq_wake_in(irq_wake_in), .ale_out(ale_out),
    .idle_out(idle_out), .power_down_out(power_down_out), .baud_double_out(baud_double_out));
`default_nettype wire

// ### bwsc_window_map.sv
/*
 * Combinational translation of a direct address through the bank window.
 * Assumes the caller registers the result.
 */
`default_nettype none
`include "bwsc_consts.svh"
module bwsc_window_map
    import bwsc_pkg::*;
(
    input wire logic win_en_in,
    input wire bwsc_block_t block_in,
    input wire bwsc_byte_t dir_addr_in,
    output logic [11:0] ram_addr_out,
    output logic xram_sel_out
);
    // ************************************************************
    // Window decode
    // ************************************************************
    wire logic in_window;
    wire logic core_block;
    wire bwsc_block_t xram_block;
    wire logic [7:0] core_addr;
    wire logic [11:0] xram_addr;

    assign in_window = win_en_in && (dir_addr_in[7:6] == `BWSC_WIN_TAG);
    assign core_block = block_in < `BWSC_CORE_BLOCKS;
    assign core_addr = {block_in[1:0], dir_addr_in[5:0]};
    // Block 4 lands on expanded 0000h, each step adds 40h
    assign xram_block = block_in - `BWSC_CORE_BLOCKS;
    assign xram_addr = {xram_block, dir_addr_in[5:0]};

    assign ram_addr_out = !in_window ? {4'h0, dir_addr_in} :
                          core_block ? {4'h0, core_addr} : xram_addr;
    assign xram_sel_out = in_window && !core_block;
endmodule // bwsc_window_map
`default_nettype wire

// ### tb_bwsc_sysctrl.sv
/* Self-checking bench for the bank window and system control block.
   Assumes the design files and the checker are compiled before it. */
`default_nettype none
`include "bwsc_consts.svh"
module tb_bwsc_sysctrl
    import bwsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, rst_in, wr, rd, wdt, irq, hit, xsel, xen, ale, idle, pd, baud;
    bwsc_byte_t addr, wdata, dir, rdata;
    bwsc_ram_addr_t ram;
    int err_count, comparisons;
    bwsc_sysctrl bwsc_sysctrl_inst (.clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(addr),
        .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
        .sfr_hit_out(hit), .dir_addr_in(dir), .ram_addr_out(ram), .xram_sel_out(xsel),
        .xram_enable_out(xen), .wdt_reset_cause_in(wdt), .irq_wake_in(irq), .ale_out(ale),
        .idle_out(idle), .power_down_out(pd), .baud_double_out(baud));
    // ************************************************************
    // Access tasks
    // ************************************************************
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [11:0] mapped(input bwsc_byte_t a);
        return {11'h0, (a == `BWSC_OFS_BANK) || (a == `BWSC_OFS_POWER)
                       || (a == `BWSC_OFS_CONFIG)};
    endfunction
    task automatic wr_reg(input bwsc_byte_t a, input bwsc_byte_t d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
        #1 chk({11'h0, hit}, mapped(a));
    endtask
    task automatic rd_reg(input bwsc_byte_t a, input bwsc_byte_t e);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 chk({4'h0, rdata}, {4'h0, e});
        chk({11'h0, hit}, mapped(a));
    endtask
    task automatic map(input bwsc_byte_t d, input logic [11:0] e, input logic x);
        @(posedge clk_in);
        dir <= d;
        @(posedge clk_in);
        #1 chk(ram, e);
        chk({11'h0, xsel}, {11'h0, x});
    endtask
    // Twelve cycles cover two strobe periods
    task automatic ale_cnt(input logic [11:0] e);
        logic [11:0] n;
        n = 12'h0;
        repeat (12) begin
            @(posedge clk_in);
            #1 n = n + {11'h0, ale};
        end
        chk(n, e);
    endtask
    task automatic do_reset(input logic cause);
        @(posedge clk_in);
        rst_in <= 1'b1;
        wdt <= cause;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        wdt <= 1'b0;
    endtask
    task automatic pulse_wake();
        @(posedge clk_in);
        irq <= 1'b1;
        @(posedge clk_in);
        irq <= 1'b0;
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        #100000;
        err_count++;
        results();
    end
    initial begin
        logic [11:0] e;
        {rst_in, wr, rd, wdt, irq, addr, wdata, dir} = {1'b1, 4'h0, 24'h0};
        do_reset(1'b0);
        rd_reg(`BWSC_OFS_BANK, 8'h00);
        rd_reg(`BWSC_OFS_POWER, 8'h00);
        rd_reg(`BWSC_OFS_CONFIG, 8'h00);
        chk({11'h0, xen}, 12'h000);
        ale_cnt(12'h004);
        wr_reg(8'h85, 8'hff);
        rd_reg(8'h85, 8'h00);
        wr_reg(`BWSC_OFS_BANK, 8'hc8);
        rd_reg(`BWSC_OFS_BANK, 8'h88);
        map(8'h41, 12'h101, 1'b1);
        map(8'h80, 12'h080, 1'b0);
        for (int b = 0; b < 64; b++) begin
            e = (b < 4) ? {4'h0, b[1:0], 6'h3f} : 12'((b - 4) * 64 + 63);
            wr_reg(`BWSC_OFS_BANK, {2'b10, b[5:0]});
            map(8'h7f, e, b >= 4);
        end
        wr_reg(`BWSC_OFS_BANK, 8'h3f);
        map(8'h7f, 12'h07f, 1'b0);
        wr_reg(`BWSC_OFS_CONFIG, 8'h82);
        rd_reg(`BWSC_OFS_CONFIG, 8'h02);
        chk({11'h0, xen}, 12'h001);
        wr_reg(`BWSC_OFS_CONFIG, 8'h03);
        ale_cnt(12'h000);
        wr_reg(`BWSC_OFS_CONFIG, 8'h02);
        ale_cnt(12'h004);
        chk({11'h0, xen}, 12'h001);
        wr_reg(`BWSC_OFS_POWER, 8'h8c);
        rd_reg(`BWSC_OFS_POWER, 8'h8c);
        chk({11'h0, baud}, 12'h001);
        wr_reg(`BWSC_OFS_POWER, 8'h05);
        chk({10'h0, idle, baud}, 12'h002);
        pulse_wake();
        #1 chk({11'h0, idle}, 12'h000);
        wr_reg(`BWSC_OFS_POWER, 8'h03);
        pulse_wake();
        #1 chk({10'h0, pd, idle}, 12'h003);
        rd_reg(`BWSC_OFS_POWER, 8'h03);
        do_reset(1'b1);
        rd_reg(`BWSC_OFS_CONFIG, 8'h80);
        chk({11'h0, pd}, 12'h000);
        chk({11'h0, xen}, 12'h000);
        wr_reg(`BWSC_OFS_CONFIG, 8'h00);
        rd_reg(`BWSC_OFS_CONFIG, 8'h00);
        results();
    end
endmodule // tb_bwsc_sysctrl
`default_nettype wire
